//--- src/rsw_map.svh
// Register offsets, control bit positions, reset values and timing counts of the ramp sweep block
`ifndef RSW_MAP_SVH
`define RSW_MAP_SVH

`define RSW_ADDR_CTRL 8'h01
`define RSW_ADDR_JLO 8'h09
`define RSW_ADDR_JHI 8'h0a

`define RSW_BIT_RAMP_EN 19
`define RSW_BIT_ND_HIGH 18
`define RSW_BIT_ND_LOW 17
`define RSW_BIT_JUMP_EN 14
`define RSW_BIT_STAT_EN 13

`define RSW_CTRL_RESET 32'h0000_0000
`define RSW_JUMP_RESET 32'h0000_0000

// Reference clock cycles per synchronization clock cycle
`define RSW_SYNC_DIV 4
// Width of the bidirectional limit pulse in synchronization clock cycles
`define RSW_PULSE_SYNC 2

`endif

//--- src/rsw_pkg.sv
// Types shared by the ramp sweep control block
package rsw_pkg;

   typedef enum logic [1:0] {
      RSW_DWELL = 2'b00,
      RSW_ND_LOW = 2'b01,
      RSW_ND_HIGH = 2'b10,
      RSW_BIDIR = 2'b11
   } rsw_mode_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } rsw_reg_req_t;

   typedef struct packed {
      logic [31:0] upper;
      logic [31:0] lower;
      logic [31:0] step_up;
      logic [31:0] step_dn;
   } rsw_ramp_cfg_t;

   typedef struct packed {
      logic [31:0] sh_ctrl;
      logic [31:0] sh_jlo;
      logic [31:0] sh_jhi;
      logic [31:0] act_ctrl;
      logic [31:0] act_jlo;
      logic [31:0] act_jhi;
      logic [31:0] ramp;
      logic [31:0] rd_data;
      logic rd_valid;
      logic dir_s1;
      logic dir_s2;
      logic dir_prev;
      logic upd_s1;
      logic upd_s2;
      logic upd_prev;
      logic dir_up;
      logic running;
      logic status;
      logic [1:0] div_cnt;
      logic [1:0] pulse_cnt;
   } rsw_state_t;

endpackage

//--- src/rsw_step_calc.sv
// Next ramp value for one accumulator step, with band skip and limit clamp
`timescale 1ns/1ps

module rsw_step_calc
   import rsw_pkg::*;
(
   input wire logic [31:0] cur,
   input wire logic up,
   input wire logic [31:0] step,
   input wire logic [31:0] upper,
   input wire logic [31:0] lower,
   input wire logic jump_en,
   input wire logic [31:0] jlo,
   input wire logic [31:0] jhi,
   output logic [31:0] nxt,
   output logic hit,
   output logic jumped
);

   logic [32:0] sum;
   logic [32:0] dif;

   // One extra bit keeps a wrap past the word edge from looking like a small value
   always_comb
   begin
      sum = {1'b0, cur} + {1'b0, step};
      dif = {1'b0, cur} - {1'b0, step};
      nxt = cur;
      hit = 1'b0;
      jumped = 1'b0;
      if (up)
      begin
         if (jump_en && (cur < jlo) && (sum >= {1'b0, jlo}))
         begin
            nxt = jhi;
            jumped = 1'b1;
         end
         else if (sum >= {1'b0, upper})
         begin
            nxt = upper;
            hit = 1'b1;
         end
         else
         begin
            nxt = sum[31:0];
         end
      end
      else
      begin
         if (jump_en && (cur > jhi) && (dif[32] || (dif[31:0] <= jhi)))
         begin
            nxt = jlo;
            jumped = 1'b1;
         end
         else if (dif[32] || (dif[31:0] <= lower))
         begin
            nxt = lower;
            hit = 1'b1;
         end
         else
         begin
            nxt = dif[31:0];
         end
      end
   end

endmodule

//--- src/rsw_ramp_ctrl.sv
// Ramp sweep limit handling: no-dwell modes, limit status pin and band skip
//
// Summary of operation
// - Ramp counts as enabled only after an update latches the enable bit.
// - No-dwell high starts an up sweep on a rising direction edge only.
// - No-dwell high snaps to the lower limit on reaching the upper one.
// - No-dwell high ignores direction edges while a sweep runs.
// - No-dwell low mirrors high: falls on a falling edge, snaps to upper.
// - Status pin is active only with ramp enable and status enable set.
// - Dwell mode: status high at the limit of the present direction.
// - Single no-dwell: status stays high after snap until next sweep.
// - Bidirectional: two sync-cycle status pulse at each limit arrival.
// - Up sweep reaching the lower jump point loads the upper jump point.
// - Down sweep reaching the upper jump point loads the lower one.
// - Rewritten jump points serve the next comparison in the same sweep.
// - Both no-dwell bits set disable jumping.
// - No-dwell bits: 10 high, 01 low, 11 bidirectional, 00 dwell.
// - Dwell mode holds the output at a reached limit.
// - Written control bits act only after a later update.
`timescale 1ns/1ps
`include "rsw_map.svh"

module rsw_ramp_ctrl
   import rsw_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire rsw_reg_req_t reg_req,
   output logic [31:0] reg_rd_data,
   output logic reg_rd_valid,
   input wire logic io_update_pin,
   input wire logic ramp_direction_pin,
   input wire rsw_ramp_cfg_t ramp_cfg,
   input wire logic step_req,
   output logic [31:0] ramp_out,
   output logic limit_reached_status_pin
);

   rsw_state_t s;
   rsw_state_t n;
   logic sync_en;
   logic upd_edge;
   logic ramp_en;
   rsw_mode_t mode;
   logic calc_up;
   logic jump_en;
   logic [31:0] nxt;
   logic hit;
   logic jumped;

   function automatic logic [31:0] reg_read(input logic [7:0] addr, input rsw_state_t st);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (addr)
         `RSW_ADDR_CTRL: v = st.sh_ctrl;
         `RSW_ADDR_JLO: v = st.sh_jlo;
         `RSW_ADDR_JHI: v = st.sh_jhi;
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   //********************************************************
   // Decode of the active (update-latched) settings
   //********************************************************
   assign sync_en = (s.div_cnt == 2'(`RSW_SYNC_DIV - 1));
   assign upd_edge = s.upd_s2 & ~s.upd_prev;
   assign ramp_en = s.act_ctrl[`RSW_BIT_RAMP_EN];
   assign mode = rsw_mode_t'(s.act_ctrl[`RSW_BIT_ND_HIGH:`RSW_BIT_ND_LOW]);
   assign jump_en = s.act_ctrl[`RSW_BIT_JUMP_EN] & (mode != RSW_BIDIR);
   // Dwell mode follows the pin level; the other modes keep their own direction
   assign calc_up = (mode == RSW_DWELL) ? s.dir_s2 : s.dir_up;

   rsw_step_calc u_calc (
      .cur(s.ramp),
      .up(calc_up),
      .step(calc_up ? ramp_cfg.step_up : ramp_cfg.step_dn),
      .upper(ramp_cfg.upper),
      .lower(ramp_cfg.lower),
      .jump_en(jump_en),
      .jlo(s.act_jlo),
      .jhi(s.act_jhi),
      .nxt(nxt),
      .hit(hit),
      .jumped(jumped)
   );

   //********************************************************
   // Next state
   //********************************************************
   always_comb
   begin
      n = s;
      n.rd_valid = reg_req.rd;
      if (reg_req.rd)
      begin
         n.rd_data = reg_read(reg_req.addr, s);
      end
      // Writes only reach the shadow copies
      if (reg_req.wr)
      begin
         unique case (reg_req.addr)
            `RSW_ADDR_CTRL: n.sh_ctrl = reg_req.wdata;
            `RSW_ADDR_JLO: n.sh_jlo = reg_req.wdata;
            `RSW_ADDR_JHI: n.sh_jhi = reg_req.wdata;
            default: n.sh_ctrl = s.sh_ctrl;
         endcase
      end
      n.dir_s1 = ramp_direction_pin;
      n.dir_s2 = s.dir_s1;
      n.upd_s1 = io_update_pin;
      n.upd_s2 = s.upd_s1;
      n.upd_prev = s.upd_s2;
      if (upd_edge)
      begin
         n.act_ctrl = s.sh_ctrl;
         n.act_jlo = s.sh_jlo;
         n.act_jhi = s.sh_jhi;
      end
      n.div_cnt = sync_en ? 2'b00 : s.div_cnt + 2'b01;
      if (sync_en)
      begin
         n.dir_prev = s.dir_s2;
         if (!ramp_en)
         begin
            // A disabled ramp rests at the lower limit, so enabling starts there
            n.ramp = ramp_cfg.lower;
            n.running = 1'b0;
            n.status = 1'b0;
            n.pulse_cnt = 2'b00;
            // Resting at the lower limit, a bidirectional run must start upward or it flags a false arrival
            n.dir_up = 1'b1;
         end
         else
         begin
            if (s.pulse_cnt != 2'b00)
            begin
               n.pulse_cnt = s.pulse_cnt - 2'b01;
            end
            unique case (mode)
               RSW_DWELL:
               begin
                  n.dir_up = s.dir_s2;
                  if (step_req)
                  begin
                     n.ramp = nxt;
                  end
                  n.status = n.dir_up ? (n.ramp == ramp_cfg.upper) : (n.ramp == ramp_cfg.lower);
               end
               RSW_ND_HIGH:
               begin
                  if (!s.running)
                  begin
                     n.ramp = ramp_cfg.lower;
                     if (s.dir_s2 && !s.dir_prev)
                     begin
                        n.running = 1'b1;
                        n.dir_up = 1'b1;
                        n.status = 1'b0;
                     end
                  end
                  else if (step_req)
                  begin
                     // Pin edges are not looked at here until the limit is hit
                     n.ramp = nxt;
                     if (hit)
                     begin
                        n.ramp = ramp_cfg.lower;
                        n.running = 1'b0;
                        n.status = 1'b1;
                     end
                  end
               end
               RSW_ND_LOW:
               begin
                  if (!s.running)
                  begin
                     n.ramp = ramp_cfg.upper;
                     if (!s.dir_s2 && s.dir_prev)
                     begin
                        n.running = 1'b1;
                        n.dir_up = 1'b0;
                        n.status = 1'b0;
                     end
                  end
                  else if (step_req)
                  begin
                     n.ramp = nxt;
                     if (hit)
                     begin
                        n.ramp = ramp_cfg.upper;
                        n.running = 1'b0;
                        n.status = 1'b1;
                     end
                  end
               end
               RSW_BIDIR:
               begin
                  if (step_req)
                  begin
                     n.ramp = nxt;
                     if (hit)
                     begin
                        n.dir_up = ~s.dir_up;
                        n.pulse_cnt = 2'(`RSW_PULSE_SYNC);
                     end
                  end
                  n.status = (n.pulse_cnt != 2'b00);
               end
            endcase
         end
      end
      if (!(n.act_ctrl[`RSW_BIT_RAMP_EN] && n.act_ctrl[`RSW_BIT_STAT_EN]))
      begin
         n.status = 1'b0;
      end
   end

   //********************************************************
   // State register
   //********************************************************
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
         s.sh_ctrl <= `RSW_CTRL_RESET;
         s.act_ctrl <= `RSW_CTRL_RESET;
         s.sh_jlo <= `RSW_JUMP_RESET;
         s.sh_jhi <= `RSW_JUMP_RESET;
         s.act_jlo <= `RSW_JUMP_RESET;
         s.act_jhi <= `RSW_JUMP_RESET;
      end
      else
      begin
         s <= n;
      end
   end

   assign reg_rd_data = s.rd_data;
   assign reg_rd_valid = s.rd_valid;
   assign ramp_out = s.ramp;
   assign limit_reached_status_pin = s.status;

   //********************************************************
   // Assertions
   //********************************************************
   a_status_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !(ramp_en && s.act_ctrl[`RSW_BIT_STAT_EN]) |-> !limit_reached_status_pin)
      else $error("status pin active while disabled");

   a_write_no_effect: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !upd_edge |=> $stable(s.act_ctrl))
      else $error("active control changed without update");

   a_enable_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
      upd_edge && s.sh_ctrl[`RSW_BIT_RAMP_EN] |=> ramp_en)
      else $error("update did not latch ramp enable");

   a_ndh_snap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sync_en && ramp_en && mode == RSW_ND_HIGH && s.running && step_req && hit
      |=> ramp_out == $past(ramp_cfg.lower) && !s.running)
      else $error("no-dwell high did not snap to lower limit");

   a_ndh_ignore: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sync_en && ramp_en && mode == RSW_ND_HIGH && s.running && !(step_req && hit)
      && !upd_edge |=> s.running && s.dir_up)
      else $error("running no-dwell sweep was disturbed");

   a_ndl_snap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sync_en && ramp_en && mode == RSW_ND_LOW && s.running && step_req && hit
      |=> ramp_out == $past(ramp_cfg.upper))
      else $error("no-dwell low did not snap to upper limit");

   a_bidir_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(limit_reached_status_pin) && mode == RSW_BIDIR && $stable(s.act_ctrl)
      && !upd_edge |-> (limit_reached_status_pin && mode == RSW_BIDIR)[*8] ##1 !limit_reached_status_pin)
      else $error("bidirectional status pulse not two sync cycles");

   a_jump_up: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sync_en && ramp_en && mode == RSW_DWELL && calc_up && step_req && jumped
      |=> ramp_out == $past(s.act_jhi))
      else $error("up sweep did not load upper jump point");

   a_jump_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      mode == RSW_BIDIR |-> !jumped)
      else $error("jump taken in bidirectional mode");

   a_dwell_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ramp_en && s.act_ctrl[`RSW_BIT_STAT_EN] && mode == RSW_DWELL && sync_en && !upd_edge
      |=> limit_reached_status_pin == (s.dir_up ? ramp_out == $past(ramp_cfg.upper)
                                                : ramp_out == $past(ramp_cfg.lower)))
      else $error("dwell status does not match limit");

endmodule

//--- sim/rsw_host_model.sv
// Host controller model: register port, update pulse, direction pin and slope timer
`timescale 1ns/1ps

module rsw_host_model
   import rsw_pkg::*;
(
   input wire logic ref_clk,
   output rsw_reg_req_t reg_req,
   input wire logic [31:0] reg_rd_data,
   input wire logic reg_rd_valid,
   output logic io_update_pin,
   output logic ramp_direction_pin,
   output logic step_req
);
   logic slow = 1'b1;
   logic [3:0] tick_cnt = 4'h0;

   initial
   begin
      reg_req = '0;
      io_update_pin = 1'b0;
      ramp_direction_pin = 1'b0;
   end

   // Slow mode leaves two idle sync ticks between steps, which jumping needs
   always @(negedge ref_clk)
   begin
      tick_cnt <= (tick_cnt == 4'hb) ? 4'h0 : tick_cnt + 4'h1;
      step_req <= !slow || tick_cnt < 4'h4;
   end

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge ref_clk);
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge ref_clk);
      reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   task rd(input logic [7:0] a, output logic [31:0] d);
      @(negedge ref_clk);
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(negedge ref_clk);
      reg_req.rd = 1'b0;
      reg_req.addr = ~a;
      // A missing answer comes back inverted so it cannot match
      d = reg_rd_valid ? reg_rd_data : ~reg_rd_data;
   endtask

   task upd();
      @(negedge ref_clk);
      io_update_pin = 1'b1;
      repeat (2) @(negedge ref_clk);
      io_update_pin = 1'b0;
   endtask

   task set_dir(input logic v);
      @(negedge ref_clk);
      ramp_direction_pin = v;
   endtask
endmodule

//--- sim/ramp_sweep_no_dwell_and_jump_tb_top.sv
// Self-checking bench of the ramp sweep control block
`timescale 1ns/1ps
`include "rsw_map.svh"

module ramp_sweep_no_dwell_and_jump_tb_top
   import rsw_pkg::*;
;
   localparam logic [31:0] c_en = 32'h0000_0001 << `RSW_BIT_RAMP_EN;
   localparam logic [31:0] c_st = 32'h0000_0001 << `RSW_BIT_STAT_EN;
   localparam logic [31:0] c_nh = 32'h0000_0001 << `RSW_BIT_ND_HIGH;
   localparam logic [31:0] c_nl = 32'h0000_0001 << `RSW_BIT_ND_LOW;
   localparam logic [31:0] c_jp = 32'h0000_0001 << `RSW_BIT_JUMP_EN;
   logic ref_clk;
   logic rst_n;
   rsw_reg_req_t reg_req;
   logic [31:0] reg_rd_data;
   logic reg_rd_valid;
   logic io_update_pin;
   logic ramp_direction_pin;
   rsw_ramp_cfg_t cfg;
   logic step_req;
   logic [31:0] ramp_out;
   logic status;
   logic [31:0] seed = 32'h0001_7ef0;
   logic [31:0] jlo, jhi, rdv;
   logic stat_en;
   logic bidir_on;
   logic [7:0] addrs [4] = '{8'h01, 8'h09, 8'h0a, 8'h55};
   int mismatches = 0;
   int n_tests = 0;
   int run_len = 0;
   int n_pulses = 0;

   rsw_ramp_ctrl i_rsw_ramp_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req),
      .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .io_update_pin(io_update_pin),
      .ramp_direction_pin(ramp_direction_pin), .ramp_cfg(cfg), .step_req(step_req),
      .ramp_out(ramp_out), .limit_reached_status_pin(status));

   rsw_host_model i_rsw_host_model (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
      .reg_rd_valid(reg_rd_valid), .io_update_pin(io_update_pin),
      .ramp_direction_pin(ramp_direction_pin), .step_req(step_req));

   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // ****************************************
   // Expectation and checking helpers
   // ****************************************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [31:0] exp_next(input logic [31:0] cur, input logic up, input logic jen);
      logic [32:0] s;
      if (up)
      begin
         s = {1'b0, cur} + {1'b0, cfg.step_up};
         if (jen && cur < jlo && s >= {1'b0, jlo})
            return jhi;
         return (s > {1'b0, cfg.upper}) ? cfg.upper : s[31:0];
      end
      // A borrow sets the top bit and means the step passed zero
      s = {1'b0, cur} - {1'b0, cfg.step_dn};
      if (jen && cur > jhi && (s[32] || s[31:0] <= jhi))
         return jlo;
      return (s[32] || s[31:0] < cfg.lower) ? cfg.lower : s[31:0];
   endfunction

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task test_done();
      if (mismatches == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task wt(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task setmode(input logic [31:0] c);
      i_rsw_host_model.wr(`RSW_ADDR_CTRL, c);
      i_rsw_host_model.upd();
   endtask

   task band(input logic [11:0] off);
      jlo = cfg.lower + {20'h0_0000, off} + (rnd() & 32'h0000_00ff);
      jhi = jlo + 32'h0000_0200;
      i_rsw_host_model.wr(`RSW_ADDR_JLO, jlo);
      i_rsw_host_model.wr(`RSW_ADDR_JHI, jhi);
      i_rsw_host_model.upd();
   endtask

   // Follows one sweep step by step; md 0 dwell, 1 single no-dwell, 2 bidirectional
   task follow(input logic up, input logic jen, input int md, input logic tog, input logic rej,
      input logic [31:0] start);
      logic [31:0] prev, e, tgt, snapv;
      int k, n;
      prev = start;
      tgt = up ? cfg.upper : cfg.lower;
      snapv = up ? cfg.lower : cfg.upper;
      n = 0;
      if (md != 2)
         i_rsw_host_model.set_dir(up);
      do
      begin
         e = exp_next(prev, up, jen);
         if (md == 1 && e == tgt)
            e = snapv;
         k = 0;
         while (ramp_out === prev && k < 200)
         begin
            @(negedge ref_clk);
            k++;
         end
         if (k == 200)
         begin
            mismatches++;
            test_done();
         end
         chk(ramp_out, e);
         if (md != 2 || e == tgt)
            chk({31'h0, status}, {31'h0, stat_en && e == (md == 1 ? snapv : tgt)});
         if (rej && up && e == jhi)
         begin
            rej = 1'b0;
            band(12'ha00);
         end
         if (tog && n == 2)
         begin
            i_rsw_host_model.set_dir(!up);
            wt(3);
            i_rsw_host_model.set_dir(up);
         end
         prev = e;
         n++;
      end
      while (e != (md == 1 ? snapv : tgt));
   endtask

   // Pulse width in reference cycles while the bidirectional mode runs
   always @(negedge ref_clk)
   begin
      if (bidir_on && status)
         run_len <= run_len + 1;
      else if (run_len != 0)
      begin
         chk(32'(run_len), 32'h0000_0008);
         n_pulses++;
         run_len <= 0;
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      rst_n = 1'b0;
      stat_en = 1'b1;
      bidir_on = 1'b0;
      cfg = '0;
      wt(16);
      rst_n = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         i_rsw_host_model.rd(addrs[i], rdv);
         chk(rdv, 32'h0000_0000);
      end
      i_rsw_host_model.wr(8'h55, 32'hffff_ffff);
      i_rsw_host_model.rd(8'h55, rdv);
      chk(rdv, 32'h0000_0000);
      for (int t = 0; t < 2; t++)
      begin
         cfg.lower = rnd() & 32'h00ff_ffff;
         cfg.upper = cfg.lower + 32'h0000_1000;
         // First pass lands exactly on the upper limit in sweeps without a band skip
         cfg.step_up = (t == 0) ? 32'h0000_0100 : 32'h0000_0040 + (rnd() & 32'h0000_003f);
         cfg.step_dn = 32'h0000_0040 + (rnd() & 32'h0000_003f);
         wt(8);
         chk(ramp_out, cfg.lower);
         i_rsw_host_model.set_dir(1'b1);
         i_rsw_host_model.wr(`RSW_ADDR_CTRL, c_en | c_st | c_jp);
         i_rsw_host_model.rd(`RSW_ADDR_CTRL, rdv);
         chk(rdv, c_en | c_st | c_jp);
         wt(40);
         chk(ramp_out, cfg.lower);
         chk({31'h0, status}, 32'h0000_0000);
         i_rsw_host_model.set_dir(1'b0);
         band(12'h400);
         wt(10);
         chk({31'h0, status}, 32'h0000_0001);
         follow(1'b1, 1'b1, 0, 1'b0, 1'b1, cfg.lower);
         follow(1'b0, 1'b1, 0, 1'b0, 1'b0, cfg.upper);
         wt(40);
         chk(ramp_out, cfg.lower);
         stat_en = 1'b0;
         setmode(c_en);
         wt(10);
         follow(1'b1, 1'b0, 0, 1'b0, 1'b0, cfg.lower);
         stat_en = 1'b1;
         setmode(32'h0000_0000);
         i_rsw_host_model.set_dir(1'b0);
         setmode(c_en | c_st | c_nh);
         wt(10);
         follow(1'b1, 1'b0, 1, 1'b1, 1'b0, cfg.lower);
         wt(40);
         chk(ramp_out, cfg.lower);
         chk({31'h0, status}, 32'h0000_0001);
         i_rsw_host_model.set_dir(1'b0);
         wt(40);
         chk(ramp_out, cfg.lower);
         follow(1'b1, 1'b0, 1, 1'b0, 1'b0, cfg.lower);
         setmode(32'h0000_0000);
         setmode(c_en | c_st | c_nl);
         wt(10);
         chk(ramp_out, cfg.upper);
         follow(1'b0, 1'b0, 1, 1'b1, 1'b0, cfg.upper);
         setmode(32'h0000_0000);
         wt(10);
         i_rsw_host_model.slow = 1'b0;
         bidir_on = 1'b1;
         n_pulses = 0;
         setmode(c_en | c_st | c_nh | c_nl | c_jp);
         follow(1'b1, 1'b0, 2, 1'b0, 1'b0, cfg.lower);
         follow(1'b0, 1'b0, 2, 1'b0, 1'b0, cfg.upper);
         wt(12);
         bidir_on = 1'b0;
         chk(32'(n_pulses), 32'h0000_0002);
         setmode(32'h0000_0000);
         i_rsw_host_model.slow = 1'b1;
      end
      test_done();
   end
endmodule
